// ==== include/pdr_pkg.sv ====
// Constants, field layout and types of the DMA auxiliary register bank
package pdr_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int REG_W = 8;
  localparam int LINE_W = 8;
  localparam int FLAG_W = 6;
  localparam int CYC_W = 4;

  // ------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_RUN = 6'h01;
  localparam logic [5:0] IDX_DIR = 6'h02;
  localparam logic [5:0] IDX_VALUE = 6'h03;
  localparam logic [5:0] IDX_MASK0 = 6'h04;
  localparam logic [5:0] IDX_MASK1 = 6'h05;
  localparam logic [5:0] IDX_FLAGS = 6'h06;
  localparam logic [5:0] IDX_LEVELS = 6'h07;
  localparam logic [5:0] IDX_OUT_START = 6'h08;
  localparam logic [5:0] IDX_OUT_IRQ = 6'h0c;
  localparam logic [5:0] IDX_OUT_END = 6'h10;
  localparam logic [5:0] IDX_OUT_CUR = 6'h14;
  localparam logic [5:0] IDX_IN_START = 6'h18;
  localparam logic [5:0] IDX_IN_IRQ = 6'h1c;
  localparam logic [5:0] IDX_IN_END = 6'h20;
  localparam logic [5:0] IDX_IN_CUR = 6'h24;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CTRL_MODE_BIT = 7;
  localparam int CTRL_IRQ_MODE_BIT = 6;
  localparam int CTRL_CYC_LSB = 4;
  localparam int CTRL_SER_RST_BIT = 2;
  localparam int CTRL_DMA_RST_BIT = 1;
  localparam int CTRL_EXT_RST_BIT = 0;
  localparam int RUN_EN_BIT = 0;
  localparam int RUN_RESTART_BIT = 1;
  localparam int FLG_OUT_IRQ = 0;
  localparam int FLG_OUT_END = 1;
  localparam int FLG_IN_IRQ = 2;
  localparam int FLG_IN_END = 3;
  localparam int FLG_MABORT = 4;
  localparam int FLG_TABORT = 5;

  // ------------------------------------------------------------
  // Reset values and writable bits
  // ------------------------------------------------------------
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [31:0] RST_ADDR = 32'h0000_0000;
  localparam logic [5:0] RST_FLAGS = 6'h00;
  localparam logic [7:0] CTRL_WMASK = 8'hf7;
  localparam logic [7:0] RUN_WMASK = 8'h03;
  localparam logic [7:0] MASK0_WMASK = 8'h3f;

  // ------------------------------------------------------------
  // Peripheral bus cycle counts and DMA address step
  // ------------------------------------------------------------
  localparam logic [3:0] PIB_CYC_FAST = 4'h3;
  localparam logic [3:0] PIB_CYC_MID = 4'h8;
  localparam logic [3:0] PIB_CYC_SLOW = 4'hf;
  localparam logic [31:0] ADDR_STEP = 32'h0000_0004;

  typedef enum logic [1:0] {
    CH_IDLE = 2'b00,
    CH_RUN = 2'b01,
    CH_DONE = 2'b10
  } pdr_chan_e;

endpackage : pdr_pkg

// ==== verilog/pdr_sideband.sv ====
// Eight sideband lines: output drive, enables and sampled levels
`timescale 1ns/1ps
`default_nettype none
module pdr_sideband (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [pdr_pkg::LINE_W-1:0] dir,
  input wire logic [pdr_pkg::LINE_W-1:0] value,
  input wire logic [pdr_pkg::LINE_W-1:0] pin_i,
  output logic [pdr_pkg::LINE_W-1:0] pin_o,
  output logic [pdr_pkg::LINE_W-1:0] pin_oe,
  output logic [pdr_pkg::LINE_W-1:0] levels
);
  import pdr_pkg::*;

  typedef struct packed {
    logic [LINE_W-1:0] levels;
  } pdr_sb_s;

  pdr_sb_s st_q;
  pdr_sb_s st_d;

  // Sample every line, driven or not, so reads see the real wire
  always_comb begin
    st_d = st_q;
    st_d.levels = pin_i;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Only lines set as outputs are driven
  assign pin_o = value;
  assign pin_oe = dir;
  assign levels = st_q.levels;

endmodule : pdr_sideband
`default_nettype wire

// ==== verilog/pdr_dma_chan.sv ====
// Address walker of one bus-master DMA channel
`timescale 1ns/1ps
`default_nettype none
module pdr_dma_chan (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic soft_rst,
  input wire logic enable,
  input wire logic halt,
  input wire logic normal_mode,
  input wire logic restart,
  input wire logic step,
  input wire logic [31:0] start_addr,
  input wire logic [31:0] irq_addr,
  input wire logic [31:0] end_addr,
  output logic [31:0] cur_addr,
  output logic busy,
  output logic at_irq,
  output logic at_end
);
  import pdr_pkg::*;

  typedef struct packed {
    pdr_chan_e state;
    logic [31:0] cur;
  } pdr_ch_s;

  pdr_ch_s st_q;
  pdr_ch_s st_d;

  // Walk from start to end one word per step
  always_comb begin
    st_d = st_q;
    unique case (st_q.state)
      CH_IDLE: begin
        if (enable && !halt) begin
          st_d.cur = start_addr;
          st_d.state = CH_RUN;
        end
      end
      CH_RUN: begin
        if (!enable || halt) begin
          st_d.state = CH_IDLE;
        end else if (step) begin
          if (st_q.cur == end_addr) begin
            if (normal_mode) begin
              st_d.state = CH_DONE;
            end else begin
              st_d.cur = start_addr;
            end
          end else begin
            st_d.cur = st_q.cur + ADDR_STEP;
          end
        end
      end
      CH_DONE: begin
        if (!enable || halt) begin
          st_d.state = CH_IDLE;
        end else if (restart) begin
          st_d.cur = start_addr;
          st_d.state = CH_RUN;
        end
      end
      default: begin
        st_d.state = CH_IDLE;
      end
    endcase
    // A held soft reset parks the walker
    if (soft_rst) begin
      st_d.state = CH_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{state: CH_IDLE, cur: RST_ADDR};
    end else begin
      st_q <= st_d;
    end
  end

  assign cur_addr = st_q.cur;
  assign busy = (st_q.state == CH_RUN);
  assign at_irq = (st_q.state != CH_IDLE) && (st_q.cur == irq_addr);
  assign at_end = (st_q.state != CH_IDLE) && (st_q.cur == end_addr);

endmodule : pdr_dma_chan
`default_nettype wire

// ==== verilog/pdr_regbank.sv ====
// APB register bank steering two DMA channels, sideband lines and resets
`timescale 1ns/1ps
`default_nettype none
module pdr_regbank (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pdr_pkg::ADDR_W-1:0] paddr,
  input wire logic [pdr_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [pdr_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic outbound_step,
  input wire logic inbound_step,
  input wire logic master_abort,
  input wire logic target_abort,
  output logic dma_run,
  output logic dma_reset,
  output logic tdm_serial_port_reset,
  output logic peripheral_reset_out_pin,
  output logic [pdr_pkg::CYC_W-1:0] pib_read_cycles,
  output logic [pdr_pkg::CYC_W-1:0] pib_write_cycles,
  output logic [31:0] outbound_addr,
  output logic outbound_busy,
  output logic [31:0] inbound_addr,
  output logic inbound_busy,
  output logic irq0,
  output logic irq1,
  input wire logic [pdr_pkg::LINE_W-1:0] sideband_i,
  output logic [pdr_pkg::LINE_W-1:0] sideband_o,
  output logic [pdr_pkg::LINE_W-1:0] sideband_oe
);
  import pdr_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [REG_W-1:0] ctrl;
    logic [REG_W-1:0] run;
    logic [REG_W-1:0] dir;
    logic [REG_W-1:0] value;
    logic [REG_W-1:0] mask0;
    logic [REG_W-1:0] mask1;
    logic [FLAG_W-1:0] flags;
    logic [3:0] live_prev;
    logic halted;
    logic [31:0] out_start;
    logic [31:0] out_irq;
    logic [31:0] out_end;
    logic [31:0] in_start;
    logic [31:0] in_irq;
    logic [31:0] in_end;
    logic [DATA_W-1:0] rdata;
  } pdr_bank_s;

  pdr_bank_s st_q;
  pdr_bank_s st_d;

  logic [31:0] out_cur;
  logic [31:0] in_cur;
  logic out_at_irq;
  logic out_at_end;
  logic in_at_irq;
  logic in_at_end;
  logic [LINE_W-1:0] levels;
  logic [3:0] live;
  logic setup;
  logic wr_acc;
  logic restart;
  logic [5:0] widx;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------

  // Merge write data into a word under the byte strobes
  function automatic logic [31:0] merge_strb(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_strb

  // Merge into an 8-bit register through lane 0 and a writable mask
  function automatic logic [7:0] merge8(
    input logic [7:0] old,
    input logic [31:0] wd,
    input logic [3:0] strb,
    input logic [7:0] wmask
  );
    logic [7:0] r;
    r = old;
    if (strb[0]) begin
      r = (old & ~wmask) | (wd[7:0] & wmask);
    end
    return r;
  endfunction : merge8

  // True for every index that holds a register
  function automatic logic is_mapped(input logic [5:0] idx);
    logic r;
    r = 1'b0;
    if (idx <= IDX_LEVELS) begin
      r = 1'b1;
    end else if (idx[1:0] == 2'b00 && idx <= IDX_IN_CUR) begin
      r = 1'b1;
    end
    return r;
  endfunction : is_mapped

  // Read cycle length chosen by the two-bit timing field
  function automatic logic [3:0] read_cycles(input logic [1:0] sel);
    logic [3:0] r;
    r = PIB_CYC_SLOW;
    if (sel == 2'b00) begin
      r = PIB_CYC_FAST;
    end else if (sel == 2'b01) begin
      r = PIB_CYC_MID;
    end
    return r;
  endfunction : read_cycles

  // ------------------------------------------------------------
  // Bus phases
  // ------------------------------------------------------------
  assign widx = paddr[7:2];
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;

  // A zero-wait slave; the read word was captured in setup
  assign pready = psel && penable;
  assign pslverr = psel && penable && !is_mapped(widx);
  assign prdata = st_q.rdata;

  // Restart fires only on a written 0-to-1 of the restart bit
  assign restart = wr_acc && (widx == IDX_RUN) && pstrb[0]
                   && pwdata[RUN_RESTART_BIT]
                   && !st_q.run[RUN_RESTART_BIT];

  assign live = {in_at_end, in_at_irq, out_at_end, out_at_irq};

  // ------------------------------------------------------------
  // Register file and flag update
  // ------------------------------------------------------------
  always_comb begin
    logic [FLAG_W-1:0] clr;
    logic [FLAG_W-1:0] set;
    clr = '0;
    set = '0;
    st_d = st_q;
    st_d.live_prev = live;

    // Read word captured at setup, held through the access phase
    if (setup && !pwrite) begin
      st_d.rdata = '0;
      unique case (widx)
        IDX_CTRL: st_d.rdata[7:0] = st_q.ctrl;
        IDX_RUN: st_d.rdata[7:0] = st_q.run;
        IDX_DIR: st_d.rdata[7:0] = st_q.dir;
        IDX_VALUE: st_d.rdata[7:0] = levels;
        IDX_MASK0: st_d.rdata[7:0] = st_q.mask0;
        IDX_MASK1: st_d.rdata[7:0] = st_q.mask1;
        IDX_FLAGS: st_d.rdata[5:0] = st_q.flags;
        IDX_LEVELS: st_d.rdata[7:0] = levels;
        IDX_OUT_START: st_d.rdata = st_q.out_start;
        IDX_OUT_IRQ: st_d.rdata = st_q.out_irq;
        IDX_OUT_END: st_d.rdata = st_q.out_end;
        IDX_OUT_CUR: st_d.rdata = out_cur;
        IDX_IN_START: st_d.rdata = st_q.in_start;
        IDX_IN_IRQ: st_d.rdata = st_q.in_irq;
        IDX_IN_END: st_d.rdata = st_q.in_end;
        IDX_IN_CUR: st_d.rdata = in_cur;
        default: st_d.rdata = '0;
      endcase
    end

    // Writes take effect at the access edge; read-only words ignore them
    if (wr_acc) begin
      unique case (widx)
        IDX_CTRL: st_d.ctrl = merge8(st_q.ctrl, pwdata, pstrb, CTRL_WMASK);
        IDX_RUN: st_d.run = merge8(st_q.run, pwdata, pstrb, RUN_WMASK);
        IDX_DIR: st_d.dir = merge8(st_q.dir, pwdata, pstrb, 8'hff);
        IDX_VALUE: st_d.value = merge8(st_q.value, pwdata, pstrb, 8'hff);
        IDX_MASK0: st_d.mask0 = merge8(st_q.mask0, pwdata, pstrb, MASK0_WMASK);
        IDX_MASK1: st_d.mask1 = merge8(st_q.mask1, pwdata, pstrb, 8'hff);
        IDX_FLAGS: begin
          if (pstrb[0]) begin
            clr = pwdata[FLAG_W-1:0];
          end
        end
        IDX_OUT_START: st_d.out_start = merge_strb(st_q.out_start, pwdata, pstrb);
        IDX_OUT_IRQ: st_d.out_irq = merge_strb(st_q.out_irq, pwdata, pstrb);
        IDX_OUT_END: st_d.out_end = merge_strb(st_q.out_end, pwdata, pstrb);
        IDX_IN_START: st_d.in_start = merge_strb(st_q.in_start, pwdata, pstrb);
        IDX_IN_IRQ: st_d.in_irq = merge_strb(st_q.in_irq, pwdata, pstrb);
        IDX_IN_END: st_d.in_end = merge_strb(st_q.in_end, pwdata, pstrb);
        default: begin
        end
      endcase
    end

    // Sticky mode catches the rising edge of each address match
    set[3:0] = live & ~st_q.live_prev;
    set[FLG_MABORT] = master_abort;
    set[FLG_TABORT] = target_abort;

    // An event in the clearing cycle survives the clear
    st_d.flags = (st_q.flags & ~clr) | set;
    if (!st_q.ctrl[CTRL_IRQ_MODE_BIT]) begin
      // Live mode mirrors the match; a clear cannot hide it
      st_d.flags[3:0] = live;
    end

    // An abort halts both channels until the DMA reset is pulsed
    if (master_abort || target_abort) begin
      st_d.halted = 1'b1;
    end else if (st_q.ctrl[CTRL_DMA_RST_BIT]) begin
      st_d.halted = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{ctrl: RST_REG8, run: RST_REG8, dir: RST_REG8,
                value: RST_REG8, mask0: RST_REG8, mask1: RST_REG8,
                flags: RST_FLAGS, live_prev: 4'h0, halted: 1'b0,
                out_start: RST_ADDR, out_irq: RST_ADDR, out_end: RST_ADDR,
                in_start: RST_ADDR, in_irq: RST_ADDR, in_end: RST_ADDR,
                rdata: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------
  // DMA channels
  // ------------------------------------------------------------

  // Outbound: memory to serial port
  pdr_dma_chan u_out_chan (
    .pclk(pclk),
    .presetn(presetn),
    .soft_rst(st_q.ctrl[CTRL_DMA_RST_BIT]),
    .enable(st_q.run[RUN_EN_BIT]),
    .halt(st_q.halted),
    .normal_mode(st_q.ctrl[CTRL_MODE_BIT]),
    .restart(restart),
    .step(outbound_step),
    .start_addr(st_q.out_start),
    .irq_addr(st_q.out_irq),
    .end_addr(st_q.out_end),
    .cur_addr(out_cur),
    .busy(outbound_busy),
    .at_irq(out_at_irq),
    .at_end(out_at_end)
  );

  // Inbound: serial port to memory
  pdr_dma_chan u_in_chan (
    .pclk(pclk),
    .presetn(presetn),
    .soft_rst(st_q.ctrl[CTRL_DMA_RST_BIT]),
    .enable(st_q.run[RUN_EN_BIT]),
    .halt(st_q.halted),
    .normal_mode(st_q.ctrl[CTRL_MODE_BIT]),
    .restart(restart),
    .step(inbound_step),
    .start_addr(st_q.in_start),
    .irq_addr(st_q.in_irq),
    .end_addr(st_q.in_end),
    .cur_addr(in_cur),
    .busy(inbound_busy),
    .at_irq(in_at_irq),
    .at_end(in_at_end)
  );

  // ------------------------------------------------------------
  // Sideband lines
  // ------------------------------------------------------------
  pdr_sideband u_sideband (
    .pclk(pclk),
    .presetn(presetn),
    .dir(st_q.dir),
    .value(st_q.value),
    .pin_i(sideband_i),
    .pin_o(sideband_o),
    .pin_oe(sideband_oe),
    .levels(levels)
  );

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------

  // Run is dropped while halted so an abort cannot keep the engines going
  assign dma_run = st_q.run[RUN_EN_BIT] && !st_q.halted;
  assign dma_reset = st_q.ctrl[CTRL_DMA_RST_BIT];
  assign tdm_serial_port_reset = st_q.ctrl[CTRL_SER_RST_BIT];
  assign peripheral_reset_out_pin = st_q.ctrl[CTRL_EXT_RST_BIT];

  // Write strobe is one clock shorter than the read strobe
  assign pib_read_cycles = read_cycles(st_q.ctrl[CTRL_CYC_LSB +: 2]);
  assign pib_write_cycles = read_cycles(st_q.ctrl[CTRL_CYC_LSB +: 2]) - 4'h1;

  assign outbound_addr = out_cur;
  assign inbound_addr = in_cur;

  // Interrupt lines; the host is expected to write back what it read
  assign irq0 = |(st_q.flags & st_q.mask0[FLAG_W-1:0]);
  assign irq1 = |(levels & ~st_q.dir & st_q.mask1);

endmodule : pdr_regbank
`default_nettype wire

// ==== tb/pdr_chk.sv ====
// Port-level assertions for the register bank
`timescale 1ns/1ps
`default_nettype none
module pdr_chk
  import pdr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pdr_pkg::ADDR_W-1:0] paddr,
  input wire logic [pdr_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic master_abort,
  input wire logic dma_run,
  input wire logic dma_reset,
  input wire logic tdm_serial_port_reset,
  input wire logic peripheral_reset_out_pin,
  input wire logic [pdr_pkg::CYC_W-1:0] pib_read_cycles,
  input wire logic [pdr_pkg::CYC_W-1:0] pib_write_cycles,
  input wire logic outbound_busy,
  input wire logic inbound_busy,
  input wire logic [pdr_pkg::LINE_W-1:0] sideband_oe
);
  logic wr_any;
  logic wr_ctrl;
  logic wr_run;
  logic wr_dir;
  // Committed byte-0 writes, decoded per register
  assign wr_any = psel && penable && pwrite && pstrb[0];
  assign wr_ctrl = wr_any && paddr[7:2] == IDX_CTRL;
  assign wr_run = wr_any && paddr[7:2] == IDX_RUN;
  assign wr_dir = wr_any && paddr[7:2] == IDX_DIR;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_zero_wait: assert property (pready == (psel && penable))
    else $error("pready is not the zero wait answer");
  chk_cyc_legal: assert property (pib_read_cycles inside {4'h3, 4'h8, 4'hf})
    else $error("read cycle count illegal");
  chk_cyc_decode: assert property (wr_ctrl |=> pib_read_cycles ==
    ($past(pwdata[5:4]) == 2'h0 ? 4'h3 : ($past(pwdata[5]) ? 4'hf : 4'h8)))
    else $error("read cycle count decode wrong");
  chk_wr_shorter: assert property (pib_write_cycles == pib_read_cycles - 4'h1)
    else $error("write cycle count not one less");
  chk_ser_rst: assert property (wr_ctrl |=> tdm_serial_port_reset == $past(pwdata[2]))
    else $error("serial reset not following control");
  chk_dma_rst: assert property (wr_ctrl |=> dma_reset == $past(pwdata[1]))
    else $error("dma reset not following control");
  chk_rst_idle: assert property (dma_reset |=> !outbound_busy && !inbound_busy)
    else $error("channel busy under dma reset");
  chk_ext_pin: assert property (wr_ctrl |=> peripheral_reset_out_pin == $past(pwdata[0]))
    else $error("reset pin level wrong");
  chk_run_off: assert property (wr_run && !pwdata[0] |-> ##[1:2] !dma_run)
    else $error("dma still running after stop");
  chk_abort_halt: assert property (master_abort |-> ##[1:2] !dma_run)
    else $error("dma not halted by abort");
  chk_dir_hold: assert property ($changed(sideband_oe) |-> $past(wr_dir))
    else $error("line enables changed without a write");
  chk_err_access: assert property (pslverr |-> pready)
    else $error("error outside access cycle");
  cover property (wr_ctrl);
  cover property (master_abort);
  cover property (pslverr);
endmodule : pdr_chk
bind pdr_regbank pdr_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .pready, .pslverr, .master_abort, .dma_run, .dma_reset, .tdm_serial_port_reset,
  .peripheral_reset_out_pin, .pib_read_cycles, .pib_write_cycles, .outbound_busy,
  .inbound_busy, .sideband_oe);
`default_nettype wire

// ==== tb/pdr_far_model.sv ====
// Far-side stand-in: DMA word mover and the outside sideband pins
`timescale 1ns/1ps
`default_nettype none
module pdr_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic outbound_busy,
  input wire logic inbound_busy,
  input wire logic slow,
  input wire logic [7:0] ext,
  input wire logic [7:0] sideband_o,
  input wire logic [7:0] sideband_oe,
  output logic outbound_step,
  output logic inbound_step,
  output logic [7:0] sideband_i
);
  logic ph_q;
  // One word a cycle, or every other cycle while the memory side stalls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= 1'h0;
      outbound_step <= 1'h0;
      inbound_step <= 1'h0;
    end else begin
      ph_q <= ~ph_q;
      outbound_step <= outbound_busy && (!slow || ph_q);
      inbound_step <= inbound_busy && (!slow || !ph_q);
    end
  end
  // Driven lines read back their own level; the others follow the outside
  assign sideband_i = (sideband_oe & sideband_o) | (~sideband_oe & ext);
endmodule : pdr_far_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pdr_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, slow;
  logic master_abort, target_abort, outbound_step, inbound_step, dma_run, dma_reset;
  logic tdm_serial_port_reset, peripheral_reset_out_pin, outbound_busy, inbound_busy;
  logic irq0, irq1;
  logic [7:0] paddr, ext, sideband_i, sideband_o, sideband_oe;
  logic [31:0] pwdata, prdata, r, outbound_addr, inbound_addr;
  logic [3:0] pstrb, pib_read_cycles, pib_write_cycles;
  int n_fail, tests_run;
  pdr_regbank dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .outbound_step, .inbound_step, .master_abort, .target_abort,
    .dma_run, .dma_reset, .tdm_serial_port_reset, .peripheral_reset_out_pin, .pib_read_cycles,
    .pib_write_cycles, .outbound_addr, .outbound_busy, .inbound_addr, .inbound_busy, .irq0,
    .irq1, .sideband_i, .sideband_o, .sideband_oe);
  pdr_far_model fm (.pclk, .presetn, .outbound_busy, .inbound_busy, .slow, .ext, .sideband_o,
    .sideband_oe, .outbound_step, .inbound_step, .sideband_i);
  // 50 MHz clock
  always #10 pclk = ~pclk;
  task automatic chk(input logic [31:0] v, input logic [31:0] x);
    tests_run++;
    if (v !== x) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, v, x);
    end
  endtask : chk
  // One APB transfer; an idle edge first keeps back-to-back calls race free
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d, 4'hf);
    repeat (2) @(negedge pclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'h0, a, 32'h0, 4'hf);
    chk(r, x);
    // Callers then look at outputs away from the launching edge
    @(negedge pclk);
  endtask : rd
  // Bounded wait until both channels have finished
  task automatic idle_wait();
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while ((outbound_busy | inbound_busy) !== 1'h0 && n < 100);
    chk(outbound_busy | inbound_busy, 1'h0);
  endtask : idle_wait
  task automatic t_reset();
    for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0);
    rd(8'h50, 32'h0);
  endtask : t_reset
  task automatic t_ctrl();
    logic [3:0] cyc [4];
    cyc = '{4'h3, 4'h8, 4'hf, 4'hf};
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, {26'h0, 2'(i), 4'hd});
      chk(pib_read_cycles, cyc[i]);
      chk(pib_write_cycles, cyc[i] - 4'h1);
      chk({tdm_serial_port_reset, peripheral_reset_out_pin}, 2'h3);
      rd(8'h00, {26'h0, 2'(i), 4'h5});
    end
    wr(8'h00, 32'h0);
    chk({tdm_serial_port_reset, peripheral_reset_out_pin}, 2'h0);
  endtask : t_ctrl
  task automatic t_side();
    @(posedge pclk);
    ext <= 8'h3c;
    wr(8'h08, 32'h0f);
    wr(8'h0c, 32'ha5);
    wr(8'h1c, 32'hff);
    wr(8'h14, 32'h30);
    chk({sideband_oe, sideband_o}, 16'h0fa5);
    rd(8'h0c, 32'h35);
    rd(8'h1c, 32'h35);
    chk(irq1, 1'h1);
    wr(8'h14, 32'h03);
    chk(irq1, 1'h0);
  endtask : t_side
  task automatic t_dma();
    logic [31:0] av [6];
    av = '{32'h100, 32'h104, 32'h108, 32'h200, 32'h200, 32'h204};
    for (int i = 0; i < 6; i++) wr(8'(32 + 16 * i + (i > 2 ? 16 : 0)), av[i]);
    rd(8'h30, 32'h104);
    rd(8'h70, 32'h200);
    wr(8'h10, 32'h3f);
    wr(8'h00, 32'hc0);
    wr(8'h04, 32'h01);
    idle_wait();
    chk(outbound_addr, 32'h108);
    chk(inbound_addr, 32'h204);
    rd(8'h50, 32'h108);
    rd(8'h90, 32'h204);
    rd(8'h18, 32'h0f);
    chk(irq0, 1'h1);
    wr(8'h18, r);
    rd(8'h18, 32'h0);
    chk(irq0, 1'h0);
    wr(8'h04, 32'h03);
    idle_wait();
    rd(8'h18, 32'h0f);
    wr(8'h18, r);
  endtask : t_dma
  task automatic t_abort();
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h04, 32'h01);
    @(posedge pclk);
    slow <= 1'h1;
    repeat (40) @(negedge pclk);
    chk(outbound_busy, 1'h1);
    chk(outbound_addr >= 32'h100 && outbound_addr <= 32'h108, 1'h1);
    wr(8'h10, 32'h10);
    @(posedge pclk);
    {master_abort, target_abort} <= 2'h3;
    @(posedge pclk);
    {master_abort, target_abort} <= 2'h0;
    repeat (3) @(negedge pclk);
    chk({dma_run, irq0}, 2'h1);
    rd(8'h18, 32'h30);
    chk(r & 32'h30, 32'h30);
    wr(8'h18, 32'h10);
    chk(irq0, 1'h0);
    wr(8'h00, 32'h02);
    chk({dma_reset, outbound_busy, inbound_busy}, 3'h4);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h01);
    chk(dma_run, 1'h1);
    wr(8'h04, 32'h0);
    chk({dma_run, outbound_busy}, 2'h0);
  endtask : t_abort
  task automatic t_misc();
    apb(1'h0, 8'ha0, 32'h0, 4'hf);
    chk(e, 1'h1);
    chk(r, 32'h0);
    wr(8'h70, 32'h11223344);
    apb(1'h1, 8'h70, 32'haabbccdd, 4'h4);
    rd(8'h70, 32'h11bb3344);
  endtask : t_misc
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  // Watchdog: the whole sequence needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    end_of_test();
  end
  initial begin
    pclk = 1'h0;
    presetn = 1'h0;
    {psel, penable, pwrite, master_abort, target_abort, slow} = 6'h0;
    {paddr, ext, pstrb, pwdata} = 52'h0;
    n_fail = 0;
    tests_run = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_ctrl();
    t_side();
    t_dma();
    t_abort();
    t_misc();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
